/* dasp_top.sv */
// Display address stepper with access arbitration and register slave
`timescale 1ns/1ps
module dasp_top
   import dasp_pkg::*;
(
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   // AHB-Lite slave
   input  wire logic              i_hsel,
   input  wire logic [31:0]       i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic                   o_hreadyout,
   output logic [31:0]            o_hrdata,
   output logic                   o_hresp,
   // Raster timing pins
   input  wire logic              i_disp_active,
   input  wire logic              i_frame_start,
   // Draw and refresh requests, same clock
   input  wire logic              i_draw_req,
   input  wire logic              i_refresh_req,
   // Frame buffer access
   output logic [ADDR_W-1:0]      o_fb_addr,
   output logic                   o_disp_cycle,
   output logic                   o_draw_cycle,
   output logic                   o_refresh_cycle,
   // Shift register loading figures
   output logic [4:0]             o_pix_per_word,
   output logic [8:0]             o_pix_per_access
);
   //-------------------------------------------------------------------
   // Register state
   //-------------------------------------------------------------------
   logic                   en_reg;
   logic                   ilv_reg;
   logic                   prio_reg;
   logic [2:0]             depth_reg;
   logic [STEP_W-1:0]      step_reg;
   logic [ADDR_W-1:0]      start_reg;
   logic [WIDTH_W-1:0]     memw_reg;
   logic [WIDTH_W-1:0]     scrw_reg;

   // Bus pipeline
   logic                   wr_pend_reg;
   logic [7:0]             wr_ofs_reg;
   logic                   acc_ok;
   logic [31:0]            rd_mux;

   // Raster address state, kept in half words for the half step
   logic [ADDR_W:0]        addr_half_reg;
   logic [ADDR_W-1:0]      line_start_reg;
   logic [WIDTH_W:0]       count_reg;
   logic                   done_reg;
   logic [ADDR_W-1:0]      rfsh_cnt_reg;

   // Slot timing
   logic [SLOT_W-1:0]      slot_cnt_reg;
   logic                   last_disp_reg;
   dasp_slot_t             slot_kind;

   // Synchronised pins and edges
   logic                   act_s;
   logic                   frame_s;
   logic                   act_d_reg;
   logic                   frame_d_reg;
   logic                   line_end;
   logic                   frame_go;

   // Step helpers
   logic [STEP_W-1:0]      step_mag;
   logic [ADDR_W:0]        step_ext;
   logic [WIDTH_W:0]       count_next;
   logic [ADDR_W-1:0]      next_line;
   logic                   disp_need;
   logic                   slot_start;

   //-------------------------------------------------------------------
   // Pin synchronisers
   //-------------------------------------------------------------------
   dasp_sync u_sync_act (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    (i_disp_active),
      .o_sync     (act_s)
   );

   dasp_sync u_sync_frame (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    (i_frame_start),
      .o_sync     (frame_s)
   );

   // Edge history taken from the settled second stage
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         act_d_reg   <= 1'b0;
         frame_d_reg <= 1'b0;
      end else begin
         act_d_reg   <= act_s;
         frame_d_reg <= frame_s;
      end
   end

   assign line_end = act_d_reg & ~act_s;
   assign frame_go = frame_s & ~frame_d_reg;

   //-------------------------------------------------------------------
   // AHB-Lite slave
   //-------------------------------------------------------------------
   // Only word accesses from an active transfer count
   assign acc_ok = i_hsel & i_hready & i_htrans[1] & (i_hsize == 3'h2);

   // Read word for the address now in its address phase
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_haddr[7:0])
         OFS_CTRL: begin
            rd_mux[CTRL_EN_BIT]   = en_reg;
            rd_mux[CTRL_ILV_BIT]  = ilv_reg;
            rd_mux[CTRL_PRIO_BIT] = prio_reg;
            rd_mux[CTRL_DEPTH_LSB +: 3] = depth_reg;
         end
         OFS_STEP:  rd_mux[STEP_W-1:0]  = step_reg;
         OFS_START: rd_mux[ADDR_W-1:0]  = start_reg;
         OFS_MEMW:  rd_mux[WIDTH_W-1:0] = memw_reg;
         OFS_SCRW:  rd_mux[WIDTH_W-1:0] = scrw_reg;
         OFS_STATUS: begin
            rd_mux[ADDR_W-1:0]    = addr_half_reg[ADDR_W:1];
            rd_mux[STAT_DONE_BIT] = done_reg;
            rd_mux[STAT_ACT_BIT]  = act_s;
         end
         OFS_PACK: begin
            rd_mux[4:0]  = o_pix_per_word;
            rd_mux[16:8] = o_pix_per_access;
         end
         default:   rd_mux = 32'h0000_0000;   // Unmapped reads zero
      endcase
      if (i_haddr[31:8] != 24'h00_0000) begin
         rd_mux = 32'h0000_0000;
      end
   end

   // Zero wait states: read data captured as the address is taken
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_hrdata    <= 32'h0000_0000;
         wr_pend_reg <= 1'b0;
         wr_ofs_reg  <= 8'h00;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         wr_pend_reg <= acc_ok & i_hwrite &
                        (i_haddr[31:8] == 24'h00_0000);
         wr_ofs_reg  <= i_haddr[7:0];
         if (acc_ok & ~i_hwrite) begin
            o_hrdata <= rd_mux;
         end
      end
   end

   // Writes land in the data phase; read-only offsets ignore them
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         en_reg    <= 1'b0;
         ilv_reg   <= 1'b0;
         prio_reg  <= 1'b0;
         depth_reg <= RST_DEPTH;
         step_reg  <= STEP_ONE;
         start_reg <= RST_START;
         memw_reg  <= RST_MEMW;
         scrw_reg  <= RST_SCRW;
      end else if (wr_pend_reg) begin
         unique case (wr_ofs_reg)
            OFS_CTRL: begin
               en_reg    <= i_hwdata[CTRL_EN_BIT];
               ilv_reg   <= i_hwdata[CTRL_ILV_BIT];
               prio_reg  <= i_hwdata[CTRL_PRIO_BIT];
               depth_reg <= i_hwdata[CTRL_DEPTH_LSB +: 3];
            end
            OFS_STEP:  step_reg  <= i_hwdata[STEP_W-1:0];
            OFS_START: start_reg <= i_hwdata[ADDR_W-1:0];
            OFS_MEMW:  memw_reg  <= i_hwdata[WIDTH_W-1:0];
            OFS_SCRW:  scrw_reg  <= i_hwdata[WIDTH_W-1:0];
            default: begin
            end
         endcase
      end
   end

   //-------------------------------------------------------------------
   // Step arithmetic
   //-------------------------------------------------------------------
   // Half word units let a step of one half advance every other access
   always_comb begin
      step_mag   = step_reg[STEP_W-1] ? STEP_W'(-step_reg) : step_reg;
      step_ext   = {{(ADDR_W+1-STEP_W){step_reg[STEP_W-1]}}, step_reg};
      count_next = count_reg + (WIDTH_W+1)'(step_mag);
      next_line  = line_start_reg + ADDR_W'(memw_reg);
   end

   //-------------------------------------------------------------------
   // Access slot timing
   //-------------------------------------------------------------------
   // Every slot has the same length, whatever the pixel depth
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         slot_cnt_reg <= '0;
      end else if (slot_cnt_reg == SLOT_W'(SLOT_CYC - 1)) begin
         slot_cnt_reg <= '0;
      end else begin
         slot_cnt_reg <= slot_cnt_reg + 1'b1;
      end
   end

   assign slot_start = (slot_cnt_reg == '0);
   assign disp_need  = en_reg & act_s & ~done_reg;

   // Who owns the next slot
   always_comb begin
      slot_kind = DASP_IDLE;
      if (i_refresh_req & ~act_s) begin
         slot_kind = DASP_RFSH;
      end else if (ilv_reg) begin
         // Display then draw in turn while the raster is live
         if (disp_need & ~last_disp_reg) begin
            slot_kind = DASP_DISP;
         end else if (i_draw_req) begin
            slot_kind = DASP_DRAW;
         end
      end else if (disp_need & ~(prio_reg & i_draw_req)) begin
         slot_kind = DASP_DISP;
      end else if (i_draw_req & (prio_reg | ~act_s)) begin
         // With display first, drawing waits for flyback
         slot_kind = DASP_DRAW;
      end
   end

   // Interleave phase; a draw slot or idle hands back to display
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         last_disp_reg <= 1'b0;
      end else if (slot_start) begin
         last_disp_reg <= (slot_kind == DASP_DISP);
      end
   end

   //-------------------------------------------------------------------
   // Raster address generation
   //-------------------------------------------------------------------
   // Frame start beats raster end when both arrive together
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         addr_half_reg  <= '0;
         line_start_reg <= RST_START;
         count_reg      <= '0;
         done_reg       <= 1'b0;
      end else if (frame_go) begin
         line_start_reg <= start_reg;
         addr_half_reg  <= {start_reg, 1'b0};
         count_reg      <= '0;
         done_reg       <= 1'b0;
      end else if (line_end) begin
         line_start_reg <= next_line;
         addr_half_reg  <= {next_line, 1'b0};
         count_reg      <= '0;
         done_reg       <= 1'b0;
      end else if (slot_start && slot_kind == DASP_DISP) begin
         addr_half_reg <= addr_half_reg + step_ext;
         count_reg     <= count_next;
         // Stop after one screen width of words
         if (count_next >= {scrw_reg, 1'b0}) begin
            done_reg <= 1'b1;
         end
      end
   end

   // Refresh row counter
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rfsh_cnt_reg <= '0;
      end else if (slot_start && slot_kind == DASP_RFSH) begin
         rfsh_cnt_reg <= rfsh_cnt_reg + 1'b1;
      end
   end

   //-------------------------------------------------------------------
   // Frame buffer outputs
   //-------------------------------------------------------------------
   // Strobes pulse for one cycle at slot start; address holds the slot.
   // Draw address belongs to the drawing datapath, so it is not driven.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_fb_addr       <= '0;
         o_disp_cycle    <= 1'b0;
         o_draw_cycle    <= 1'b0;
         o_refresh_cycle <= 1'b0;
      end else begin
         o_disp_cycle    <= slot_start && slot_kind == DASP_DISP;
         o_draw_cycle    <= slot_start && slot_kind == DASP_DRAW;
         o_refresh_cycle <= slot_start && slot_kind == DASP_RFSH;
         if (slot_start && slot_kind == DASP_DISP) begin
            o_fb_addr <= addr_half_reg[ADDR_W:1];
         end else if (slot_start && slot_kind == DASP_RFSH) begin
            // Stepped fetches skew rows, so shift refresh by one
            o_fb_addr <= (step_reg != STEP_ONE) ?
                         rfsh_cnt_reg + REFRESH_OFFSET :
                         rfsh_cnt_reg;
         end
      end
   end

   //-------------------------------------------------------------------
   // Packing figures for the shift register logic
   //-------------------------------------------------------------------
   dasp_pack u_pack (
      .i_core_clk       (i_core_clk),
      .i_sys_rst        (i_sys_rst),
      .i_depth_code     (depth_reg),
      .i_step_mag       (step_mag),
      .o_pix_per_word   (o_pix_per_word),
      .o_pix_per_access (o_pix_per_access)
   );
endmodule

/* dasp_pkg.sv */
// Constants, register map and timing for the display address stepper
//----------------------------------------------------------------------
// What this block does
//----------------------------------------------------------------------
package dasp_pkg;
   //-------------------------------------------------------------------
   // Widths
   //-------------------------------------------------------------------
   localparam int ADDR_W   = 20;          // Word address, one word each
   localparam int WORD_W   = 16;          // Bits per frame buffer word
   localparam int WIDTH_W  = 12;          // Memory and screen width
   localparam int STEP_W   = 7;           // Signed step in half words

   //-------------------------------------------------------------------
   // Register byte offsets
   //-------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STEP   = 8'h04;
   localparam logic [7:0] OFS_START  = 8'h08;
   localparam logic [7:0] OFS_MEMW   = 8'h0C;
   localparam logic [7:0] OFS_SCRW   = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_PACK   = 8'h18;

   //-------------------------------------------------------------------
   // Control fields
   //-------------------------------------------------------------------
   localparam int CTRL_EN_BIT    = 0;     // Display fetch enable
   localparam int CTRL_ILV_BIT   = 1;     // Interleaved access mode
   localparam int CTRL_PRIO_BIT  = 2;     // Draw wins in single mode
   localparam int CTRL_DEPTH_LSB = 4;     // Depth code, 3 bits
   localparam int STAT_DONE_BIT  = 24;
   localparam int STAT_ACT_BIT   = 25;

   //-------------------------------------------------------------------
   // Reset values
   //-------------------------------------------------------------------
   localparam logic [2:0]         RST_DEPTH = 3'h0;   // One bit per pixel
   localparam logic [STEP_W-1:0]  STEP_ONE  = 7'h02;  // +1 word
   localparam logic [ADDR_W-1:0]  RST_START = 20'h0_0000;
   localparam logic [WIDTH_W-1:0] RST_MEMW  = 12'h080;
   localparam logic [WIDTH_W-1:0] RST_SCRW  = 12'h080;
   localparam logic [ADDR_W-1:0]  REFRESH_OFFSET = 20'h0_0001;

   //-------------------------------------------------------------------
   // Timing
   //-------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int FB_CYCLE_NS   = 250;    // One frame buffer access
   localparam int SLOT_CYC = (FB_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
   localparam int SLOT_W   = 7;

   typedef enum logic [1:0] {
      DASP_IDLE,
      DASP_DISP,
      DASP_DRAW,
      DASP_RFSH
   } dasp_slot_t;
endpackage

/* dasp_sync.sv */
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module dasp_sync
   import dasp_pkg::*;
(
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   // Level
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         meta_reg <= 1'b0;
         o_sync   <= 1'b0;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end
endmodule

/* dasp_pack.sv */
// Pixel packing figures for the external shift register logic
`timescale 1ns/1ps
module dasp_pack
   import dasp_pkg::*;
(
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   // Settings
   input  wire logic [2:0]        i_depth_code,
   input  wire logic [STEP_W-1:0] i_step_mag,
   // Figures
   output logic [4:0]             o_pix_per_word,
   output logic [8:0]             o_pix_per_access
);
   logic [2:0] code;
   logic [4:0] ppw;
   logic [9:0] prod;

   // Codes above sixteen bits fall back to sixteen
   always_comb begin
      code = (i_depth_code > 3'h4) ? 3'h4 : i_depth_code;
      ppw  = 5'h10 >> code;
      prod = 10'(ppw) * 10'(i_step_mag);
   end

   // Step is in half words, so halve the product
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_pix_per_word   <= 5'h10;
         o_pix_per_access <= 9'h010;
      end else begin
         o_pix_per_word   <= ppw;
         o_pix_per_access <= prod[9:1];
      end
   end
endmodule

/* dasp_checker.sv */
// Port checker for the display address stepper, with its bind
`timescale 1ns/1ps
module dasp_checker
   import dasp_pkg::*;
(
   // Clock, reset and bus
   input wire logic              i_core_clk,
   input wire logic              i_sys_rst,
   input wire logic              i_hsel,
   input wire logic [1:0]        i_htrans,
   input wire logic              i_hwrite,
   input wire logic [2:0]        i_hsize,
   input wire logic              i_hready,
   input wire logic              o_hreadyout,
   input wire logic [31:0]       o_hrdata,
   input wire logic              o_hresp,
   // Frame buffer side
   input wire logic              i_draw_req,
   input wire logic              i_refresh_req,
   input wire logic [ADDR_W-1:0] o_fb_addr,
   input wire logic              o_disp_cycle,
   input wire logic              o_draw_cycle,
   input wire logic              o_refresh_cycle,
   input wire logic [4:0]        o_pix_per_word,
   input wire logic [8:0]        o_pix_per_access
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   //------------------
   // Helpers
   //------------------
   logic       any_stb;
   logic       rd_take;
   logic       seen_reg;
   logic [6:0] gap_reg;
   // Any slot strobe, and a word read taken on the bus
   assign any_stb = o_disp_cycle | o_draw_cycle | o_refresh_cycle;
   assign rd_take = i_hsel & i_hready & i_htrans[1] & ~i_hwrite
                    & (i_hsize == 3'b010);
   // Slot grid phase; the first strobe after reset only arms the check
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || any_stb || gap_reg == 7'(SLOT_CYC - 1)) begin
         gap_reg <= 7'h00;
      end else begin
         gap_reg <= gap_reg + 7'h01;
      end
   end
   // Set once a strobe has been seen since reset
   always_ff @(posedge i_core_clk) begin
      seen_reg <= ~i_sys_rst & (seen_reg | any_stb);
   end
   //------------------
   // Properties
   //------------------
   sequence s_strobe; any_stb; endsequence
   sequence s_quiet; !any_stb [*8]; endsequence
   property p_bus_okay; o_hreadyout && !o_hresp; endproperty
   property p_rdata_hold; !rd_take |=> $stable(o_hrdata); endproperty
   property p_one_slot;
      $onehot0({o_disp_cycle, o_draw_cycle, o_refresh_cycle});
   endproperty
   property p_slot_quiet; s_strobe |=> s_quiet; endproperty
   property p_slot_grid;
      any_stb && seen_reg |-> gap_reg == 7'(SLOT_CYC - 1);
   endproperty
   property p_draw_cause; o_draw_cycle |-> $past(i_draw_req); endproperty
   property p_rfsh_cause;
      o_refresh_cycle |-> $past(i_refresh_req);
   endproperty
   property p_addr_hold;
      $changed(o_fb_addr) |-> o_disp_cycle || o_refresh_cycle;
   endproperty
   property p_ppw_onehot; $onehot(o_pix_per_word); endproperty
   property p_ppa_bound;
      o_pix_per_access <= {o_pix_per_word, 4'h0};
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus slave stalled or gave an error");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   a_one_slot: assert property (p_one_slot)
      else $error("two access kinds in one slot");
   a_slot_quiet: assert property (p_slot_quiet)
      else $error("strobe too soon after another");
   a_slot_grid: assert property (p_slot_grid)
      else $error("strobe off the slot grid");
   a_draw_cause: assert property (p_draw_cause)
      else $error("draw slot without a draw request");
   a_rfsh_cause: assert property (p_rfsh_cause)
      else $error("refresh slot without a request");
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved outside a display or refresh");
   a_ppw_onehot: assert property (p_ppw_onehot)
      else $error("pixels per word not a power of two");
   a_ppa_bound: assert property (p_ppa_bound)
      else $error("pixels per access beyond sixteen words");
endmodule

bind dasp_top dasp_checker chk (
   .i_core_clk, .i_sys_rst, .i_hsel, .i_htrans, .i_hwrite, .i_hsize,
   .i_hready, .o_hreadyout, .o_hrdata, .o_hresp, .i_draw_req,
   .i_refresh_req, .o_fb_addr, .o_disp_cycle, .o_draw_cycle,
   .o_refresh_cycle, .o_pix_per_word, .o_pix_per_access
);

/* dasp_fb_model.sv */
// Frame buffer and video shift register model that logs display and refresh addresses and only counts draw accesses
`timescale 1ns/1ps
module dasp_fb_model
   import dasp_pkg::*;
(
   // Clock and log clear
   input  wire logic              i_core_clk,
   input  wire logic              i_clr,
   // Access strobes
   input  wire logic [ADDR_W-1:0] i_fb_addr,
   input  wire logic              i_disp_cycle,
   input  wire logic              i_draw_cycle,
   input  wire logic              i_refresh_cycle
);
   logic [ADDR_W-1:0] disp_log [16];
   logic [ADDR_W-1:0] rfsh_log [4];
   int                n_disp;
   int                n_draw;
   int                n_rfsh;
   //------------------
   // Access log
   //------------------
   // Display words load the shift chain; draw data path is not modelled.
   // Counts move by non-blocking update so a reader on the edge sees
   // the totals up to the previous edge, never a half-updated value.
   always @(posedge i_core_clk) begin
      if (i_clr) begin
         n_disp <= 0;
         n_draw <= 0;
         n_rfsh <= 0;
      end else begin
         if (i_disp_cycle) begin
            disp_log[n_disp % 16] <= i_fb_addr;
            n_disp <= n_disp + 1;
         end
         if (i_refresh_cycle) begin
            rfsh_log[n_rfsh % 4] <= i_fb_addr;
            n_rfsh <= n_rfsh + 1;
         end
         n_draw <= n_draw + int'(i_draw_cycle);
      end
   end
endmodule

/* tb_display_address_stepper.sv */
// Self-checking bench for the display address stepper
`timescale 1ns/1ps
module tb_display_address_stepper;
   import dasp_pkg::*;
   //------------------
   // Signals
   //------------------
   logic              i_core_clk, i_sys_rst, i_hsel, i_hwrite, clr;
   logic              i_disp_active, i_frame_start, i_draw_req;
   logic              i_refresh_req, o_hreadyout, o_hresp;
   logic              o_disp_cycle, o_draw_cycle, o_refresh_cycle;
   logic [31:0]       i_haddr, i_hwdata, o_hrdata;
   logic [1:0]        i_htrans;
   logic [2:0]        i_hsize;
   logic [ADDR_W-1:0] o_fb_addr;
   logic [4:0]        o_pix_per_word;
   logic [8:0]        o_pix_per_access;
   wire logic         i_hready;
   int                failures, samples_checked;
   localparam int ST [5] = '{1, 2, 4, 32, 124};
   localparam int PA [5] = '{8, 16, 32, 256, 32};
   localparam int RS [3] = '{4, 1, -4};
   localparam int RN [3] = '{2, 8, 2};
   localparam int RT [8] = '{0, 2, 0, 32'h80, 32'h80, 0, 32'h1010, 0};
   assign i_hready = o_hreadyout;
   dasp_top uut (
      .i_core_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
      .i_hsize, .i_hwdata, .i_hready, .o_hreadyout, .o_hrdata, .o_hresp,
      .i_disp_active, .i_frame_start, .i_draw_req, .i_refresh_req,
      .o_fb_addr, .o_disp_cycle, .o_draw_cycle, .o_refresh_cycle,
      .o_pix_per_word, .o_pix_per_access);
   dasp_fb_model fb (
      .i_core_clk, .i_clr(clr), .i_fb_addr(o_fb_addr),
      .i_disp_cycle(o_disp_cycle), .i_draw_cycle(o_draw_cycle),
      .i_refresh_cycle(o_refresh_cycle));
   //------------------
   // Tasks
   //------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] e);
      samples_checked++;
      if (seen !== e) begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (i_hready !== 1'b1 && n < 20);
      if (i_hready !== 1'b1) begin
         failures++;
         print_verdict();
      end
   endtask
   // One single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      i_hsel <= 1'b1;
      i_haddr <= {24'h00_0000, a};
      i_hwrite <= w;
      i_htrans <= 2'b10;
      wait_ready();
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      wait_ready();
      rd = o_hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, e);
   endtask
   task automatic clear();
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
   endtask
   task automatic frame();
      i_frame_start <= 1'b1;
      cyc(8);
      i_frame_start <= 1'b0;
      cyc(8);
   endtask
   // One raster of twelve slots, then three slots of flyback
   task automatic raster(input int s, input int n, input int base);
      clear();
      i_disp_active <= 1'b1;
      cyc(756);
      i_disp_active <= 1'b0;
      cyc(189);
      check(32'(fb.n_disp), 32'(n));
      for (int k = 0; k < n; k++) begin
         check(32'(fb.disp_log[k]), 32'(base + ((k * s) >>> 1)));
      end
   endtask
   // Ten slots counted after the mode has settled
   task automatic win(input logic [7:0] c, input int nd, input int nw);
      wr(OFS_CTRL, 32'(c));
      cyc(63);
      clear();
      cyc(631);
      check(32'(fb.n_disp), 32'(nd));
      check(32'(fb.n_draw), 32'(nw));
   endtask
   //------------------
   // Sequence
   //------------------
   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   initial begin
      cyc(100000);
      failures++;
      print_verdict();
   end
   initial begin
      i_sys_rst = 1'b1;
      {i_hsel, i_hwrite, clr, i_disp_active, i_frame_start} = 5'h0;
      {i_draw_req, i_refresh_req, i_htrans} = 4'h0;
      {i_haddr, i_hwdata} = 64'h0;
      i_hsize = 3'b010;
      cyc(16);
      i_sys_rst <= 1'b0;
      cyc(1);
      // Reset values, the unmapped word, and the read-only pack word
      for (int k = 0; k < 8; k++) begin
         if (k != 5) rdc(8'(4 * k), 32'(RT[k]));
      end
      wr(OFS_PACK, 32'hFFFF);
      rdc(OFS_PACK, 32'h1010);
      wr(OFS_STEP, 32'h4);
      for (int d = 0; d < 5; d++) begin
         wr(OFS_CTRL, 32'(d << 4));
         rdc(OFS_CTRL, 32'(d << 4));
         rdc(OFS_PACK, 32'(((32 >> d) << 8) | (16 >> d)));
      end
      wr(OFS_CTRL, 32'h0);
      for (int k = 0; k < 5; k++) begin
         wr(OFS_STEP, 32'(ST[k]));
         rdc(OFS_STEP, 32'(ST[k]));
         check(32'(o_pix_per_access), 32'(PA[k]));
      end
      // Narrow screen inside a wider memory line, three step sizes
      wr(OFS_START, 32'h100);
      wr(OFS_MEMW, 32'h20);
      wr(OFS_SCRW, 32'h4);
      wr(OFS_CTRL, 32'h1);
      for (int k = 0; k < 3; k++) begin
         wr(OFS_STEP, 32'(7'(RS[k])));
         frame();
         raster(RS[k], RN[k], 32'h100);
         raster(RS[k], RN[k], 32'h120);
      end
      // Refresh in flyback, unit step then a two word step
      wr(OFS_STEP, 32'h2);
      clear();
      i_refresh_req <= 1'b1;
      cyc(126);
      i_refresh_req <= 1'b0;
      cyc(2);
      wr(OFS_STEP, 32'h4);
      i_refresh_req <= 1'b1;
      cyc(63);
      i_refresh_req <= 1'b0;
      cyc(2);
      check(32'(fb.n_rfsh), 32'h3);
      check(32'(fb.rfsh_log[1] - fb.rfsh_log[0]), 32'h1);
      check(32'(fb.rfsh_log[2] - fb.rfsh_log[1]), 32'h2);
      // Contention between display and drawing
      wr(OFS_SCRW, 32'h80);
      wr(OFS_STEP, 32'h2);
      frame();
      i_draw_req <= 1'b1;
      i_disp_active <= 1'b1;
      win(8'h01, 10, 0);
      win(8'h05, 0, 10);
      win(8'h45, 0, 10);
      win(8'h03, 5, 5);
      i_disp_active <= 1'b0;
      win(8'h01, 0, 10);
      print_verdict();
   end
endmodule
